/* rtl/prbc_map.svh */
/*
 Constants for the bit error rate checker: register offsets, field
 positions, reset values and counts.
 Assumes inclusion by bare name from prbc_top and tb_top.
*/
`ifndef PRBC_MAP_SVH
`define PRBC_MAP_SVH

// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define PRBC_OFF_CTRL    12'h000
`define PRBC_OFF_CFG     12'h004
`define PRBC_OFF_DLIM    12'h008
`define PRBC_OFF_ELIM    12'h00c
`define PRBC_OFF_STAT    12'h010
`define PRBC_OFF_DCNT    12'h014
`define PRBC_OFF_ECNT    12'h018
`define PRBC_OFF_IRQST   12'h01c
`define PRBC_OFF_IRQMSK  12'h020

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define PRBC_CTRL_START  0
`define PRBC_CTRL_STOP   1
`define PRBC_CFG_FALL    0
`define PRBC_CFG_INV     1
`define PRBC_CFG_MASK_LO 2
`define PRBC_CFG_REST    4
`define PRBC_CFG_TYPE_LO 8
`define PRBC_ST_RUN      0
`define PRBC_ST_TERM     1
`define PRBC_ST_CLKSEEN  2
`define PRBC_ST_SYNC     3
`define PRBC_IRQ_TERM    0
`define PRBC_IRQ_RESYNC  1

// ---------------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------------
`define PRBC_RST_DLIM    32'h0000_2710
`define PRBC_RST_ELIM    32'h0000_0064
`define PRBC_SEED_BITS   5'h18
`define PRBC_LOCK_WIN    8'h40
`define PRBC_LOCK_ERRS   8'h10
`define PRBC_LIM_MAX     32'hffff_fffe

`endif

/* rtl/prbc_pkg.sv */
/*
 Types shared by the bit error rate checker modules.
 Assumes prbc_map.svh sits beside it.
*/
package prbc_pkg;
   typedef enum logic [1:0] {
      PRBC_MASK_OFF,
      PRBC_MASK_HIGH,
      PRBC_MASK_LOW
   } prbc_mask_t;

   typedef enum logic [2:0] {
      PRBC_P9, PRBC_P11, PRBC_P15, PRBC_P16,
      PRBC_P20, PRBC_P21, PRBC_P23
   } prbc_type_t;
endpackage

/* rtl/prbc_bit_if.sv */
/*
 Interface carrying sampled bits from the front end to the core.
 Assumes a single pclk domain on both sides.
*/
`timescale 1ns/1ns
interface prbc_bit_if;
   logic bit_stb;
   logic bit_val;
   logic bit_ena;
   logic edge_seen;
   modport src (output bit_stb, output bit_val, output bit_ena,
                output edge_seen);
   modport dst (input bit_stb, input bit_val, input bit_ena,
                input edge_seen);
endinterface

/* rtl/prbc_front.sv */
/*
 Front end: synchronises DUT clock, data and data-enable pins, finds the
 selected clock edge and emits one strobe per received bit.
 Assumes the DUT clock is slower than a quarter of pclk.
*/
`timescale 1ns/1ns
module prbc_front
   import prbc_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // Pins
   input  wire logic dut_clk,
   input  wire logic dut_data,
   input  wire logic dut_den,
   // Configuration
   input  wire logic cfg_fall,
   input  wire logic cfg_inv,
   // Bits out
   prbc_bit_if.src   bo
);
   typedef struct packed {
      logic [1:0] sc;
      logic [1:0] sd;
      logic [1:0] se;
      logic       clk_d;
      logic       stb;
      logic       val;
      logic       ena;
      logic       edg;
   } prbc_front_st_t;

   prbc_front_st_t s_q, s_d;
   logic rise, fall;

   always_comb begin
      s_d = s_q;
      // Second stage only feeds logic
      s_d.sc = {s_q.sc[0], dut_clk};
      s_d.sd = {s_q.sd[0], dut_data};
      s_d.se = {s_q.se[0], dut_den};
      s_d.clk_d = s_q.sc[1];
      rise = s_q.sc[1] & ~s_q.clk_d;
      fall = ~s_q.sc[1] & s_q.clk_d;
      s_d.edg = rise | fall;
      s_d.stb = cfg_fall ? fall : rise;
      s_d.val = s_q.sd[1] ^ cfg_inv;
      s_d.ena = s_q.se[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign bo.bit_stb   = s_q.stb & ce;
   assign bo.bit_val   = s_q.val;
   assign bo.bit_ena   = s_q.ena;
   assign bo.edge_seen = s_q.edg & ce;

   // A strobe needs an edge seen by the synchroniser one cycle before
   a_stb_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
      bo.bit_stb && $past(ce) |-> $past(s_q.sc[1] != s_q.clk_d))
      else $error("strobe without edge");
   a_polarity_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !cfg_fall && fall) |=> !s_q.stb)
      else $error("falling edge taken in rising mode");
endmodule

/* rtl/prbc_lfsr.sv */
/*
 Local PRBS generator. Loads shifted-in bits while seeding and free runs
 afterwards, predicting the next received bit.
 Assumes one advance per bit strobe.
*/
`timescale 1ns/1ns
module prbc_lfsr
   import prbc_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   // Control
   input  wire prbc_type_t ptype,
   input  wire logic       adv,
   input  wire logic       load,
   input  wire logic       din,
   // Prediction
   output logic            pred
);
   logic [22:0] sr_q, sr_d;

   function automatic logic tap(input prbc_type_t t,
                                input logic [22:0] s);
      case (t)
         PRBC_P9:  tap = s[8] ^ s[4];
         PRBC_P11: tap = s[10] ^ s[8];
         PRBC_P15: tap = s[14] ^ s[13];
         PRBC_P16: tap = s[15] ^ s[14] ^ s[12] ^ s[3];
         PRBC_P20: tap = s[19] ^ s[2];
         PRBC_P21: tap = s[20] ^ s[18];
         PRBC_P23: tap = s[22] ^ s[17];
         default:  tap = s[8] ^ s[4];
      endcase
   endfunction

   always_comb begin
      pred = tap(ptype, sr_q);
      sr_d = sr_q;
      if (adv) begin
         sr_d = {sr_q[21:0], load ? din : pred};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_q <= '0;
      end else if (ce) begin
         sr_q <= sr_d;
      end
   end
endmodule

/* rtl/prbc_top.sv */
/*
 Bit error rate checker top: APB registers, seeding, compare, counters,
 stop conditions, resynchronisation and interrupt.
 Assumes an APB master on pclk and a DUT driving clock, data and enable
 pins asynchronously to pclk.
*/
// The implementer's own choices: the address map and the APB slave port.
// Behaviour
// - The checker works with DUT bit clocks from about 100 Hz to 20 MHz.
// - Data are sampled on the chosen clock edge with chosen polarity.
// - The first 24 bits seed the local generator, then compare starts.
// - Every compared bit is counted, and every mismatch separately.
// - Error and data counts stay readable when a test ends.
// - Failed lock clears the sync flag and restarts the measurement.
// - The test ends when the data count reaches its limit.
// - The test ends when the error count reaches its own limit.
// - A stop request ends a running test at once.
// - Reset restores the documented default configuration.
// - Terminated and clock-seen flags report stop and clock activity.
`timescale 1ns/1ns
`include "prbc_map.svh"
module prbc_top
   import prbc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // DUT pins
   input  wire logic        dut_clk,
   input  wire logic        dut_data,
   input  wire logic        dut_den,
   // Interrupt
   output logic             irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_SEED, ST_RUN, ST_DONE} prbc_st_t;

   typedef struct packed {
      prbc_st_t    st;
      logic        fall;
      logic        inv;
      prbc_mask_t  mask;
      logic        rest_ext;
      prbc_type_t  ptype;
      logic [31:0] dlim;
      logic [31:0] elim;
      logic [31:0] dcnt;
      logic [31:0] ecnt;
      logic [4:0]  seed;
      logic [7:0]  win;
      logic [7:0]  werr;
      logic        term;
      logic        clk_seen;
      logic        sync;
      logic [1:0]  irq_st;
      logic [1:0]  irq_msk;
      logic [31:0] rdata;
   } prbc_top_st_t;

   prbc_top_st_t s_q, s_d;
   prbc_bit_if   bi ();
   logic         pred, counted, mism, wr, rd;
   logic         adv, load;
   logic [1:0]   ev;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction

   // -------------------------------------------------------------------
   // Front end and generator
   // -------------------------------------------------------------------
   prbc_front u_front (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .dut_clk  (dut_clk),
      .dut_data (dut_data),
      .dut_den  (dut_den),
      .cfg_fall (s_q.fall),
      .cfg_inv  (s_q.inv),
      .bo       (bi.src)
   );

   prbc_lfsr u_lfsr (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .ptype   (s_q.ptype),
      .adv     (adv),
      .load    (load),
      .din     (bi.bit_val),
      .pred    (pred)
   );

   // -------------------------------------------------------------------
   // Core logic
   // -------------------------------------------------------------------
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign counted = bi.bit_stb &&
      (s_q.mask == PRBC_MASK_OFF ||
       (s_q.mask == PRBC_MASK_HIGH && bi.bit_ena) ||
       (s_q.mask == PRBC_MASK_LOW && !bi.bit_ena));
   assign adv  = counted && (s_q.st == ST_SEED || s_q.st == ST_RUN);
   assign load = (s_q.st == ST_SEED);
   assign mism = bi.bit_val != pred;

   always_comb begin
      s_d = s_q;
      ev = 2'b00;
      if (bi.edge_seen && s_q.st != ST_IDLE) begin
         s_d.clk_seen = 1'b1;
      end
      case (s_q.st)
         ST_IDLE: ;
         ST_SEED: begin
            if (counted) begin
               s_d.seed = s_q.seed + 5'h01;
               if (s_q.seed == `PRBC_SEED_BITS - 5'h01) begin
                  s_d.st = ST_RUN;
                  s_d.sync = 1'b1;
                  s_d.win = '0;
                  s_d.werr = '0;
               end
            end
         end
         ST_RUN: begin
            if (counted) begin
               s_d.dcnt = s_q.dcnt + 32'h1;
               if (mism) begin
                  s_d.ecnt = s_q.ecnt + 32'h1;
               end
               if (s_q.win != `PRBC_LOCK_WIN) begin
                  s_d.win = s_q.win + 8'h01;
                  s_d.werr = s_q.werr + {7'h0, mism};
               end
               if (s_q.win != `PRBC_LOCK_WIN &&
                   s_q.werr + {7'h0, mism} >= `PRBC_LOCK_ERRS) begin
                  // Lock lost early: restart from seeding
                  s_d.sync = 1'b0;
                  s_d.st = ST_SEED;
                  s_d.seed = '0;
                  s_d.dcnt = '0;
                  s_d.ecnt = '0;
                  ev[`PRBC_IRQ_RESYNC] = 1'b1;
               end else if (s_d.dcnt >= s_q.dlim ||
                            s_d.ecnt >= s_q.elim) begin
                  s_d.st = ST_DONE;
                  s_d.term = 1'b1;
                  ev[`PRBC_IRQ_TERM] = 1'b1;
               end
            end
         end
         ST_DONE: ;
         default: s_d.st = ST_IDLE;
      endcase
      // Register writes; hardware sets win over IRQST write-one clears
      if (wr) begin
         if (hit(paddr, `PRBC_OFF_CTRL)) begin
            if (pwdata[`PRBC_CTRL_STOP] && s_q.st != ST_IDLE &&
                s_q.st != ST_DONE) begin
               s_d.st = ST_DONE;
               s_d.term = 1'b1;
               ev[`PRBC_IRQ_TERM] = 1'b1;
            end else if (pwdata[`PRBC_CTRL_START]) begin
               s_d.st = ST_SEED;
               s_d.seed = '0;
               s_d.dcnt = '0;
               s_d.ecnt = '0;
               s_d.term = 1'b0;
               s_d.clk_seen = 1'b0;
               s_d.sync = 1'b0;
            end
         end
         if (hit(paddr, `PRBC_OFF_CFG)) begin
            s_d.fall = pwdata[`PRBC_CFG_FALL];
            s_d.inv  = pwdata[`PRBC_CFG_INV];
            s_d.mask = prbc_mask_t'(pwdata[`PRBC_CFG_MASK_LO +: 2]);
            s_d.rest_ext = pwdata[`PRBC_CFG_REST];
            s_d.ptype = prbc_type_t'(pwdata[`PRBC_CFG_TYPE_LO +: 3]);
         end
         if (hit(paddr, `PRBC_OFF_DLIM) && pwdata != 32'h0 &&
             pwdata <= `PRBC_LIM_MAX) begin
            s_d.dlim = pwdata;
         end
         if (hit(paddr, `PRBC_OFF_ELIM) && pwdata != 32'h0 &&
             pwdata <= `PRBC_LIM_MAX) begin
            s_d.elim = pwdata;
         end
         if (hit(paddr, `PRBC_OFF_IRQST)) begin
            s_d.irq_st = s_q.irq_st & ~pwdata[1:0];
         end
         if (hit(paddr, `PRBC_OFF_IRQMSK)) begin
            s_d.irq_msk = pwdata[1:0];
         end
      end
      s_d.irq_st = s_d.irq_st | ev;
      // Read data captured in setup so the access phase takes no wait
      if (rd) begin
         case (paddr)
            `PRBC_OFF_CFG: s_d.rdata = {21'h0, s_q.ptype, 3'h0,
               s_q.rest_ext, s_q.mask, s_q.inv, s_q.fall};
            `PRBC_OFF_DLIM:   s_d.rdata = s_q.dlim;
            `PRBC_OFF_ELIM:   s_d.rdata = s_q.elim;
            `PRBC_OFF_STAT:   s_d.rdata = {28'h0, s_q.sync,
               s_q.clk_seen, s_q.term,
               (s_q.st == ST_SEED || s_q.st == ST_RUN)};
            `PRBC_OFF_DCNT:   s_d.rdata = s_q.dcnt;
            `PRBC_OFF_ECNT:   s_d.rdata = s_q.ecnt;
            `PRBC_OFF_IRQST:  s_d.rdata = {30'h0, s_q.irq_st};
            `PRBC_OFF_IRQMSK: s_d.rdata = {30'h0, s_q.irq_msk};
            default:          s_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q       <= '0;
         s_q.st    <= ST_IDLE;
         s_q.mask  <= PRBC_MASK_OFF;
         s_q.ptype <= PRBC_P9;
         s_q.dlim  <= `PRBC_RST_DLIM;
         s_q.elim  <= `PRBC_RST_ELIM;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign prdata  = s_q.rdata;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign irq     = |(s_q.irq_st & s_q.irq_msk);

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   sequence seed_done;
      s_q.st == ST_SEED && counted &&
      s_q.seed == `PRBC_SEED_BITS - 5'h01;
   endsequence

   a_seed_to_run: assert property (@(posedge pclk) disable iff (!presetn)
      seed_done and (ce && !wr) |=> s_q.st == ST_RUN && s_q.sync)
      else $error("seeding did not enter compare");
   a_no_count_seed: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.st == ST_SEED |=> $stable(s_q.ecnt) || s_q.ecnt == 0)
      else $error("errors counted while seeding");
   a_data_count: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == ST_RUN && counted && !wr && s_d.st == ST_RUN
      |=> s_q.dcnt == $past(s_q.dcnt) + 1)
      else $error("data bit not counted");
   a_err_count: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == ST_RUN && counted && mism && !wr
      && s_d.st != ST_SEED |=> s_q.ecnt == $past(s_q.ecnt) + 1)
      else $error("error bit not counted");
   // Limits may be rewritten while running, so check the reaching step
   a_data_limit: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == ST_RUN && counted && !wr
      && s_d.dcnt >= s_q.dlim |=> s_q.st != ST_RUN)
      else $error("data limit overrun");
   a_err_limit: assert property (@(posedge pclk) disable iff (!presetn)
      ce && s_q.st == ST_RUN && counted && !wr
      && s_d.ecnt >= s_q.elim |=> s_q.st != ST_RUN)
      else $error("error limit overrun");
   a_stop_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr && hit(paddr, `PRBC_OFF_CTRL) && pwdata[1]
      && s_q.st inside {ST_SEED, ST_RUN} |=> s_q.st == ST_DONE
      && s_q.term)
      else $error("stop ignored");
   a_resync_flag: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(s_q.sync) && !$past(wr) |-> s_q.st == ST_SEED)
      else $error("sync lost without restart");
   a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mask == PRBC_MASK_HIGH && bi.bit_stb && !bi.bit_ena
      |-> !counted)
      else $error("masked bit counted");
   a_term_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ev[`PRBC_IRQ_TERM]
      |=> s_q.irq_st[`PRBC_IRQ_TERM] && s_q.term)
      else $error("termination not recorded");
endmodule

/* verif/prbc_dut_model.sv */
/*
 Serial source in place of the device under test: clock, PRBS data and
 data-enable pins.
 Assumes the bench holds run low between tests.
*/
`timescale 1ns/1ns
module prbc_dut_model (
   // Control
   input  wire logic        run,
   input  wire logic        inv,
   input  wire logic [22:0] taps,
   input  wire logic [15:0] err_at,
   input  wire logic [15:0] err_from,
   input  wire logic        den_alt,
   input  wire logic        den_pol,
   // Pins
   output logic             dut_clk,
   output logic             dut_data,
   output logic             dut_den
);
   logic [22:0] h;
   logic [15:0] nbit;
   logic        slot;
   logic        nb;

   initial begin
      dut_clk  = 1'b0;
      dut_data = 1'b0;
      dut_den  = 1'b0;
      forever begin
         if (!run) begin
            // Clock stands still; data wanders so no stale bit holds
            h        = '1;
            nbit     = '0;
            slot     = 1'b0;
            dut_data = ~dut_data;
            dut_den  = ~dut_den;
            #40;
         end else begin
            nb = ^(h & taps);
            if (den_alt && slot) begin
               // Filler at the wrong enable level, wrong bit too
               dut_den  = ~den_pol;
               dut_data = ~nb ^ inv;
            end else begin
               dut_den  = den_pol;
               dut_data = nb ^ inv ^ (nbit == err_at) ^ (nbit >= err_from);
               h        = {h[21:0], nb};
               nbit     = nbit + 16'h0001;
            end
            slot = den_alt & ~slot;
            // 160 ns bit period, inside the supported clock range
            #40 dut_clk = 1'b1;
            #80 dut_clk = 1'b0;
            #40;
         end
      end
   end
endmodule

/* verif/tb_top.sv */
/*
 Self-checking bench for the bit error rate checker.
 Assumes prbc_top, its package and the source model are compiled first.
*/
`timescale 1ns/1ns
`include "prbc_map.svh"
module tb_top
   import prbc_pkg::*;
();
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        dut_clk;
   logic        dut_data;
   logic        dut_den;
   logic        irq;
   logic        m_run;
   logic        m_inv;
   logic [22:0] m_taps;
   logic [15:0] m_err_at;
   logic [15:0] m_err_from;
   logic        m_den_alt;
   logic        m_den_pol;
   logic [31:0] rd;
   logic [22:0] tap_tab [7];
   int          fail_count;
   int          check_count;

   prbc_top u_dut (
      .pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dut_clk(dut_clk), .dut_data(dut_data),
      .dut_den(dut_den), .irq(irq)
   );

   prbc_dut_model u_src (
      .run(m_run), .inv(m_inv), .taps(m_taps), .err_at(m_err_at),
      .err_from(m_err_from), .den_alt(m_den_alt), .den_pol(m_den_pol),
      .dut_clk(dut_clk), .dut_data(dut_data), .dut_den(dut_den)
   );

   always #10 pclk = ~pclk;

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk("slave error", {31'h0, pslverr}, 32'h0);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask

   task automatic wait_stat(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         apb(1'b0, `PRBC_OFF_STAT, 32'h0);
         n++;
      end while ((rd & m) === 32'h0 && n < 4000);
      chk("status wait", rd & m, m);
   endtask

   task automatic begin_run(input logic [31:0] cfg, input logic [31:0] dl,
                            input logic [31:0] el);
      apb(1'b1, `PRBC_OFF_CFG, cfg);
      apb(1'b1, `PRBC_OFF_DLIM, dl);
      apb(1'b1, `PRBC_OFF_ELIM, el);
      apb(1'b1, `PRBC_OFF_IRQST, 32'h3);
      apb(1'b1, `PRBC_OFF_CTRL, 32'h1);
      rdchk("start status", `PRBC_OFF_STAT, 32'h1);
      m_run <= 1'b1;
   endtask

   task automatic end_run(input logic [31:0] dn, input logic [31:0] en);
      wait_stat(32'h2);
      m_run <= 1'b0;
      rdchk("data count", `PRBC_OFF_DCNT, dn);
      rdchk("error count", `PRBC_OFF_ECNT, en);
   endtask

   task automatic t_defaults();
      rdchk("cfg reset", `PRBC_OFF_CFG, 32'h0);
      rdchk("dlim reset", `PRBC_OFF_DLIM, 32'h0000_2710);
      rdchk("elim reset", `PRBC_OFF_ELIM, 32'h0000_0064);
      rdchk("unmapped", 12'h100, 32'h0);
      apb(1'b1, `PRBC_OFF_DLIM, 32'h0);
      rdchk("dlim zero", `PRBC_OFF_DLIM, 32'h0000_2710);
      apb(1'b1, `PRBC_OFF_ELIM, 32'hffff_ffff);
      rdchk("elim top", `PRBC_OFF_ELIM, 32'h0000_0064);
      apb(1'b1, `PRBC_OFF_DLIM, 32'hffff_fffe);
      rdchk("dlim max", `PRBC_OFF_DLIM, 32'hffff_fffe);
      $display("test defaults done");
   endtask

   task automatic t_clean();
      begin_run(32'h0, 32'h64, 32'h64);
      end_run(32'h64, 32'h0);
      rdchk("final status", `PRBC_OFF_STAT, 32'he);
      rdchk("irq status", `PRBC_OFF_IRQST, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, `PRBC_OFF_IRQMSK, 32'h1);
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, `PRBC_OFF_IRQST, 32'h1);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      apb(1'b1, `PRBC_OFF_IRQMSK, 32'h0);
      $display("test clean run done");
   endtask

   task automatic t_types();
      for (int i = 0; i < 7; i++) begin
         m_taps <= tap_tab[i];
         begin_run({21'h0, 3'(i), 8'h0}, 32'h3c, 32'h64);
         end_run(32'h3c, 32'h0);
      end
      m_taps <= tap_tab[0];
      $display("test sequence types done");
   endtask

   task automatic t_polarity();
      m_inv <= 1'b1;
      begin_run(32'h3, 32'h3c, 32'h64);
      end_run(32'h3c, 32'h0);
      m_inv <= 1'b0;
      $display("test polarity done");
   endtask

   task automatic t_errlimit();
      m_err_from <= 16'h0028;
      begin_run(32'h0, 32'h3e8, 32'h5);
      end_run(32'h15, 32'h5);
      m_err_from <= 16'hffff;
      $display("test error limit done");
   endtask

   task automatic t_stop();
      begin_run(32'h0, 32'h2710, 32'h64);
      wait_stat(32'h8);
      apb(1'b1, `PRBC_OFF_CTRL, 32'h2);
      apb(1'b0, `PRBC_OFF_STAT, 32'h0);
      chk("stopped", rd & 32'h3, 32'h2);
      repeat (200) @(posedge pclk);
      apb(1'b0, `PRBC_OFF_DCNT, 32'h0);
      chk("count frozen", {31'h0, rd < 32'h8}, 32'h1);
      m_run <= 1'b0;
      $display("test stop done");
   endtask

   task automatic t_relock();
      // A bad bit late in the seed leaves the generator out of step
      m_err_at <= 16'h0014;
      begin_run(32'h0, 32'h64, 32'h64);
      end_run(32'h64, 32'h0);
      rdchk("resync flag", `PRBC_OFF_IRQST, 32'h3);
      m_err_at <= 16'hffff;
      $display("test relock done");
   endtask

   task automatic t_mask();
      m_den_alt <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         m_den_pol <= (i == 0);
         begin_run(i == 0 ? 32'h4 : 32'h8, 32'h3c, 32'h64);
         end_run(32'h3c, 32'h0);
      end
      m_den_alt <= 1'b0;
      m_den_pol <= 1'b1;
      $display("test masking done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      pclk        = 1'b0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 12'h000;
      pwdata      = 32'h0;
      m_run       = 1'b0;
      m_inv       = 1'b0;
      m_err_at    = 16'hffff;
      m_err_from  = 16'hffff;
      m_den_alt   = 1'b0;
      m_den_pol   = 1'b1;
      fail_count  = 0;
      check_count = 0;
      tap_tab = '{23'h000110, 23'h000500, 23'h006000, 23'h00d008,
                  23'h080004, 23'h140000, 23'h420000};
      m_taps      = 23'h000110;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_defaults();
      t_clean();
      t_types();
      t_polarity();
      t_errlimit();
      t_stop();
      t_relock();
      t_mask();
      wrap_up();
   end

   initial begin
      // Whole run needs well under half of this span
      #1_500_000;
      fail_count++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule
